// *** verilog/sdm_pkg.sv ***
// Constants and feedback table for the stochastic density dimmer.
// Assumes one system clock; all users reference names as sdm_pkg::name.
//
// Notes on behaviour
// R1 - Counter steps per tick, visits every code
// R2 - Code order repeats with a fixed period
// R3 - Density register holds until next write
// R4 - Comparator is combinational, no tick wait
// R5 - Output high when density exceeds code
// R6 - Width selectable from 2 to maximum
// R7 - Full width spans all codes to maximum
// R8 - Wide counters compare as cascaded byte slices
// R9 - Output may change on every tick
// R10 - Internal tick is system clock over four
// R11 - External PWM tick accepted at any rate
// R12 - Channels may share one external tick
// R13 - Output routed to selected row net
// R14 - Width write reloads feedback polynomial
// R15 - Run control; output low while stopped
// R16 - Tick is an enable in clock domain
package sdm_pkg;

	// ******************************
	// Sizes and reset values
	// ******************************
	localparam int MAX_W = 16;
	localparam int SLICE_W = 8;
	localparam logic [4:0] MIN_WIDTH = 5'h02;
	localparam logic [4:0] RST_WIDTH = 5'h10;
	localparam logic [15:0] RST_DENSITY = 16'h0000;
	localparam int ROWS = 4;
	localparam int OUTS = 4;
	localparam logic [1:0] TICK_DIV_LAST = 2'h3; // Divide by four

	// ******************************
	// Feedback taps per width
	// ******************************
	// Maximal-length taps; bit n-1 is always set
	function automatic logic [15:0] taps_for(input logic [4:0] n);
		logic [15:0] t;
		t = 16'h0000;
		unique case (n)
			5'h02: t = 16'h0003;
			5'h03: t = 16'h0006;
			5'h04: t = 16'h000C;
			5'h05: t = 16'h0014;
			5'h06: t = 16'h0030;
			5'h07: t = 16'h0060;
			5'h08: t = 16'h00B8;
			5'h09: t = 16'h0110;
			5'h0A: t = 16'h0240;
			5'h0B: t = 16'h0500;
			5'h0C: t = 16'h0829;
			5'h0D: t = 16'h100D;
			5'h0E: t = 16'h2015;
			5'h0F: t = 16'h6000;
			default: t = 16'hD008;
		endcase
		return t;
	endfunction : taps_for

endpackage : sdm_pkg

// *** verilog/stochastic_density_dimmer.sv ***
// One stochastic density modulator channel with tick source and routing.
// Assumes all inputs are synchronous to MCLK; strobes are one cycle wide.
`timescale 1ns/1ns
module stochastic_density_dimmer #(
	parameter int W = sdm_pkg::MAX_W
) (
	// Clock and reset
	input wire logic MCLK,
	input wire logic RESET_N,
	// Tick source
	input wire logic TICK_IN,
	input wire logic TICK_SEL,
	// Software controls
	input wire logic [4:0] WIDTH_IN,
	input wire logic WIDTH_WR,
	input wire logic [W-1:0] DENSITY_IN,
	input wire logic DENSITY_WR,
	input wire logic RUN_ON,
	input wire logic RUN_OFF,
	// Routing select
	input wire logic [1:0] ROW_SEL,
	input wire logic [1:0] OUT_SEL,
	// Outputs
	output logic DIM_OUT,
	output logic [15:0] ROW_OUT,
	output logic [W-1:0] CODE_OUT,
	output logic [4:0] WIDTH_OUT,
	output logic RUNNING
);

	localparam int SLICES = (W + sdm_pkg::SLICE_W - 1) / sdm_pkg::SLICE_W;
	localparam int SW = SLICES * sdm_pkg::SLICE_W;

	logic [1:0] div_ff;
	logic int_tick_ff;
	logic tick_prev_ff;
	logic tick;
	logic run_ff;
	logic [4:0] width_ff;
	logic [4:0] nxt_width;
	logic [W-1:0] taps_ff;
	logic [W-1:0] mask_ff;
	logic [W-1:0] code_ff;
	logic [W-1:0] nxt_code;
	logic [W-1:0] density_ff;
	logic fb;
	logic gt;
	logic [SW-1:0] d_ext;
	logic [SW-1:0] c_ext;
	logic [SLICES:0] gt_chain;
	logic out_ff;
	logic [15:0] row_ff;
	logic [3:0] route_idx;

	// ******************************
	// Tick generation
	// ******************************
	// Free divider; runs even while stopped so ticks stay evenly spaced
	always_ff @(posedge MCLK) begin
		if (!RESET_N) begin
			div_ff <= 2'h0;
			int_tick_ff <= 1'b0;
		end else begin
			div_ff <= div_ff + 2'h1; // R10
			int_tick_ff <= (div_ff == sdm_pkg::TICK_DIV_LAST); // R10
		end
	end

	// Edge of external PWM tick
	always_ff @(posedge MCLK) begin
		if (!RESET_N) begin
			tick_prev_ff <= 1'b0;
		end else begin
			tick_prev_ff <= TICK_IN;
		end
	end

	// One rising edge of the PWM is one tick; rate is set by the PWM
	assign tick = TICK_SEL ? (TICK_IN & ~tick_prev_ff) : int_tick_ff; // R11 R12 R16

	// ******************************
	// Run control
	// ******************************
	// Stop wins when both strobes arrive together
	always_ff @(posedge MCLK) begin
		if (!RESET_N) begin
			run_ff <= 1'b0;
		end else if (RUN_OFF) begin
			run_ff <= 1'b0; // R15
		end else if (RUN_ON) begin
			run_ff <= 1'b1; // R15
		end
	end

	// ******************************
	// Width and polynomial
	// ******************************
	// Out-of-range widths are clamped rather than refused
	always_comb begin
		if (WIDTH_IN < sdm_pkg::MIN_WIDTH) begin
			nxt_width = sdm_pkg::MIN_WIDTH; // R6
		end else if (WIDTH_IN > 5'(W)) begin
			nxt_width = 5'(W); // R6
		end else begin
			nxt_width = WIDTH_IN;
		end
	end

	// Width write reloads taps and the in-range mask together
	always_ff @(posedge MCLK) begin
		if (!RESET_N) begin
			width_ff <= sdm_pkg::RST_WIDTH;
			taps_ff <= W'(sdm_pkg::taps_for(sdm_pkg::RST_WIDTH));
			mask_ff <= W'(17'h1FFFF);
		end else if (WIDTH_WR) begin
			width_ff <= nxt_width;
			taps_ff <= W'(sdm_pkg::taps_for(nxt_width)); // R14
			mask_ff <= W'((17'h00001 << nxt_width) - 17'h00001); // R7
		end
	end

	// ******************************
	// Pseudo-random counter
	// ******************************
	// Extra term splices the all-zero code into the sequence
	assign fb = (^(code_ff & taps_ff))
		^ ((code_ff & (mask_ff >> 1)) == '0); // R1
	assign nxt_code = ((code_ff << 1) | W'(fb)) & mask_ff;

	// Restart from zero on width change so the code stays in range
	always_ff @(posedge MCLK) begin
		if (!RESET_N) begin
			code_ff <= '0;
		end else if (WIDTH_WR) begin
			code_ff <= '0; // R2
		end else if (run_ff && tick) begin
			code_ff <= nxt_code; // R1 R9 R16
		end
	end

	// ******************************
	// Density register
	// ******************************
	always_ff @(posedge MCLK) begin
		if (!RESET_N) begin
			density_ff <= W'(sdm_pkg::RST_DENSITY);
		end else if (DENSITY_WR) begin
			density_ff <= DENSITY_IN; // R3
		end
	end

	// ******************************
	// Cascaded comparator
	// ******************************
	// Only the active width of the density takes part
	assign d_ext = SW'(density_ff & mask_ff);
	assign c_ext = SW'(code_ff);
	assign gt_chain[0] = 1'b0;

	// Each byte slice decides unless equal, then defers downward
	for (genvar s = 0; s < SLICES; s++) begin : g_slice
		logic [sdm_pkg::SLICE_W-1:0] ds;
		logic [sdm_pkg::SLICE_W-1:0] cs;
		assign ds = d_ext[s*sdm_pkg::SLICE_W +: sdm_pkg::SLICE_W];
		assign cs = c_ext[s*sdm_pkg::SLICE_W +: sdm_pkg::SLICE_W];
		assign gt_chain[s+1] = (ds > cs) | ((ds == cs) & gt_chain[s]); // R8
	end

	assign gt = gt_chain[SLICES]; // R4 R5

	// ******************************
	// Output and routing
	// ******************************
	// Registered one MCLK after the compare; no tick is waited for
	always_ff @(posedge MCLK) begin
		if (!RESET_N) begin
			out_ff <= 1'b0;
		end else begin
			out_ff <= run_ff & gt; // R4 R5 R15
		end
	end

	assign route_idx = {ROW_SEL, OUT_SEL};

	// Route the same compare result onto one of sixteen nets
	always_ff @(posedge MCLK) begin
		if (!RESET_N) begin
			row_ff <= 16'h0000;
		end else begin
			row_ff <= 16'(run_ff & gt) << route_idx; // R13
		end
	end

	assign DIM_OUT = out_ff;
	assign ROW_OUT = row_ff;
	assign CODE_OUT = code_ff;
	assign WIDTH_OUT = width_ff;
	assign RUNNING = run_ff;

	// ******************************
	// Checks
	// ******************************
	// Period helper: ticks since the code last left zero
	logic [16:0] per_cnt_ff;
	logic seen_zero_ff;
	always_ff @(posedge MCLK) begin
		if (!RESET_N || WIDTH_WR) begin
			per_cnt_ff <= 17'h00000;
			seen_zero_ff <= 1'b0;
		end else if (run_ff && tick) begin
			if (code_ff == '0) begin
				per_cnt_ff <= 17'h00001;
				seen_zero_ff <= 1'b1;
			end else begin
				per_cnt_ff <= per_cnt_ff + 17'h00001;
			end
		end
	end

	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RESET_N);

	// Compare, output, routing, counter, ticks and registers

	a_out_follows_cmp: assert property ( // R5
		(run_ff && (density_ff & mask_ff) > code_ff) |=> DIM_OUT)
		else $error("output not high above code");
	a_out_low_below: assert property ( // R4
		((density_ff & mask_ff) <= code_ff) |=> !DIM_OUT)
		else $error("output high at or below code");
	a_out_low_stopped: assert property ( // R15
		RUN_OFF |=> !run_ff ##1 !DIM_OUT)
		else $error("output not low after stop");
	a_code_in_range: assert property ( // R7
		(code_ff & ~mask_ff) == '0)
		else $error("code outside active width");
	a_code_holds: assert property ( // R16
		(!tick && !WIDTH_WR) |=> $stable(code_ff))
		else $error("code moved without a tick");
	a_density_holds: assert property ( // R3
		!DENSITY_WR |=> $stable(density_ff))
		else $error("density changed without write");
	a_taps_reload: assert property ( // R14
		WIDTH_WR |=> taps_ff == W'(sdm_pkg::taps_for($past(nxt_width))))
		else $error("taps not reloaded for width");
	a_div_tick: assert property ( // R10
		int_tick_ff |=> !int_tick_ff [*3] ##1 int_tick_ff)
		else $error("internal tick not one in four");
	a_ext_tick: assert property ( // R11 R12
		(TICK_SEL && TICK_IN && !tick_prev_ff && run_ff && !WIDTH_WR)
		|=> !$stable(code_ff))
		else $error("external tick edge missed");
	a_full_period: assert property ( // R2
		(run_ff && tick && code_ff == '0 && seen_zero_ff)
		|-> per_cnt_ff == (17'h00001 << width_ff))
		else $error("sequence period wrong");
	a_route_one: assert property ( // R13
		$onehot0(ROW_OUT) && (|ROW_OUT == DIM_OUT))
		else $error("routing not single net");
	a_route_index: assert property ( // R13
		(run_ff && gt) |=> ROW_OUT[$past(route_idx)])
		else $error("output on wrong row net");
	a_slice_match: assert property ( // R8
		gt == ((density_ff & mask_ff) > code_ff))
		else $error("cascaded compare disagrees");

	// Control strobes and register loads
	a_run_start: assert property ( // R15
		(RUN_ON && !RUN_OFF) |=> run_ff)
		else $error("run did not start");
	a_stopped_hold: assert property ( // R15
		(!run_ff && !WIDTH_WR) |=> $stable(code_ff))
		else $error("code moved while stopped");
	a_width_load: assert property ( // R6
		(WIDTH_WR && WIDTH_IN >= sdm_pkg::MIN_WIDTH
		&& WIDTH_IN <= 5'(W)) |=> width_ff == $past(WIDTH_IN))
		else $error("in-range width not taken");
	a_width_clamp: assert property ( // R6
		WIDTH_WR |=> (width_ff >= sdm_pkg::MIN_WIDTH
		&& width_ff <= 5'(W)))
		else $error("width outside supported range");
	a_width_restart: assert property ( // R2
		WIDTH_WR |=> code_ff == '0)
		else $error("code not restarted on width write");
	a_density_load: assert property ( // R3
		DENSITY_WR |=> density_ff == $past(DENSITY_IN))
		else $error("density write not taken");
	a_mask_width: assert property ( // R7
		mask_ff == W'((17'h00001 << width_ff) - 17'h00001))
		else $error("active mask does not match width");

	// ******************************
	// Cover points
	// ******************************
	// Main scenarios a run should reach at least once
	c_out_high: cover property (run_ff ##1 DIM_OUT ##1 !DIM_OUT);
	c_full_period: cover property (
		run_ff && tick && code_ff == '0 && seen_zero_ff);
	c_width_change: cover property (WIDTH_WR ##1 run_ff && tick);
	c_ext_tick: cover property (TICK_SEL && tick && run_ff);
	c_stop: cover property (RUN_OFF ##2 !DIM_OUT);

endmodule : stochastic_density_dimmer

// *** sim/led_load_model.sv ***
// Regulator-side load model: counts MCLK cycles with the dimmer on.
// Assumes dim is synchronous to clk; clr is a level from the bench.
`timescale 1ns/1ns
module led_load_model (
	// Clock and clear
	input wire logic clk,
	input wire logic clr,
	// Dimmer drive
	input wire logic dim,
	// Energy seen
	output int on_cycles
);
	// ****************
	// Energy count
	// ****************
	// On-time only; a real regulator also smooths the energy
	always_ff @(posedge clk) begin
		if (clr) begin
			on_cycles <= 0;
		end else if (dim === 1'b1) begin
			on_cycles <= on_cycles + 1;
		end
	end
endmodule : led_load_model

// *** sim/tb_stochastic_density_dimmer.sv ***
// Self-checking bench for the stochastic density dimmer.
// Assumes one 10 MHz clock; ticks come from the bench on TICK_IN until the final internal-tick check.
`timescale 1ns/1ns
module tb_stochastic_density_dimmer;
	logic MCLK, RESET_N, TICK_IN, TICK_SEL, WIDTH_WR, DENSITY_WR;
	logic RUN_ON, RUN_OFF, DIM_OUT, RUNNING, clr;
	logic [4:0] WIDTH_IN, WIDTH_OUT;
	logic [15:0] DENSITY_IN, ROW_OUT, CODE_OUT, prev;
	logic [1:0] ROW_SEL, OUT_SEL;
	logic [255:0] seen;
	int on_cycles, bad_count, cmp_count, k;
	// ****************
	// Design and load
	// ****************
	stochastic_density_dimmer #(.W(16)) dut (.MCLK(MCLK),
		.RESET_N(RESET_N), .TICK_IN(TICK_IN), .TICK_SEL(TICK_SEL),
		.WIDTH_IN(WIDTH_IN), .WIDTH_WR(WIDTH_WR),
		.DENSITY_IN(DENSITY_IN), .DENSITY_WR(DENSITY_WR),
		.RUN_ON(RUN_ON), .RUN_OFF(RUN_OFF), .ROW_SEL(ROW_SEL),
		.OUT_SEL(OUT_SEL), .DIM_OUT(DIM_OUT), .ROW_OUT(ROW_OUT),
		.CODE_OUT(CODE_OUT), .WIDTH_OUT(WIDTH_OUT), .RUNNING(RUNNING));
	led_load_model load (.clk(MCLK), .clr(clr), .dim(DIM_OUT),
		.on_cycles(on_cycles));
	// ****************
	// Helpers
	// ****************
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask : check
	// Expected output: strict greater-than against the code
	function automatic logic [15:0] exp_dim(input logic [15:0] d,
		input logic [15:0] c);
		return 16'(d > c);
	endfunction : exp_dim
	task automatic cyc(input int n);
		repeat (n) @(posedge MCLK);
		#1;
	endtask : cyc
	task automatic ctl(input logic [2:0] s);
		{WIDTH_WR, DENSITY_WR, RUN_ON} = s;
		RUN_OFF = (s == 3'h0);
		cyc(1);
		{WIDTH_WR, DENSITY_WR, RUN_ON, RUN_OFF} = 4'h0;
		cyc(2);
	endtask : ctl
	// One external tick, held long enough for the output to settle
	task automatic tick();
		TICK_IN = 1'b1;
		cyc(2);
		TICK_IN = 1'b0;
		cyc(2);
	endtask : tick
	// Period sweep; wide widths skip the period, coverage and on-time checks
	task automatic sweep(input logic [4:0] w, input logic [15:0] d);
		int n;
		n = (w > 5'h08) ? 256 : 1 << w;
		seen = '0;
		{ROW_SEL, OUT_SEL} = 4'($urandom);
		WIDTH_IN = w;
		ctl(3'h4);
		DENSITY_IN = d;
		ctl(3'h2);
		DENSITY_IN = ~d;
		ctl(3'h1);
		tick();
		prev = CODE_OUT;
		clr = 1'b0;
		for (int i = 0; i < n; i++) begin
			tick();
			seen[CODE_OUT[7:0]] = 1'b1;
			check(CODE_OUT >> w, 16'h0000);
			check(16'(DIM_OUT), exp_dim(d, CODE_OUT));
			check(ROW_OUT, 16'(DIM_OUT) << {ROW_SEL, OUT_SEL});
		end
		if (w <= 5'h08) begin
			check(CODE_OUT, prev);
			check(16'($countones(seen)), 16'(n));
			check(16'(on_cycles), 16'(4 * d));
		end
		clr = 1'b1;
		$display("sweep width %0d density %0d done", w, d);
	endtask : sweep
	task automatic end_sim();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : end_sim
	// ****************
	// Clock and limit
	// ****************
	initial begin
		MCLK = 1'b0;
		forever #50 MCLK = ~MCLK;
	end
	// Hang guard well above the longest run
	initial begin
		repeat (100000) @(posedge MCLK);
		bad_count++;
		end_sim();
	end
	// ****************
	// Main sequence
	// ****************
	initial begin
		{RESET_N, TICK_IN, WIDTH_WR, DENSITY_WR, RUN_ON, RUN_OFF} = 6'h0;
		{TICK_SEL, clr, WIDTH_IN, DENSITY_IN} = {2'h3, 21'h0};
		{ROW_SEL, OUT_SEL} = 4'h0;
		void'($urandom(32'hA155A12D));
		cyc(6);
		RESET_N = 1'b1;
		check({RUNNING, DIM_OUT, 9'h0, WIDTH_OUT}, 16'h0010);
		check(CODE_OUT, 16'h0000);
		WIDTH_IN = 5'h01;
		ctl(3'h4);
		check(16'(WIDTH_OUT), 16'h0002);
		WIDTH_IN = 5'h1F;
		ctl(3'h4);
		check(16'(WIDTH_OUT), 16'h0010);
		$display("reset and width clamp done");
		for (int w = 2; w <= 8; w++) begin
			sweep(5'(w), 16'($urandom % (1 << w)));
		end
		sweep(5'h08, 16'h00FF);
		sweep(5'h03, 16'h0000);
		sweep(5'h10, 16'($urandom));
		ctl(3'h0);
		prev = CODE_OUT;
		tick();
		check({RUNNING, DIM_OUT, CODE_OUT[13:0]}, {2'h0, prev[13:0]});
		{RUN_ON, RUN_OFF} = 2'h3;
		cyc(1);
		{RUN_ON, RUN_OFF} = 2'h0;
		cyc(1);
		check(16'(RUNNING), 16'h0000);
		$display("stop done");
		TICK_SEL = 1'b0;
		ctl(3'h1);
		check(16'(RUNNING), 16'h0001);
		k = 0;
		for (int i = 0; i < 40; i++) begin
			prev = CODE_OUT;
			cyc(1);
			k += int'(CODE_OUT !== prev);
		end
		check(16'(k), 16'h000A);
		$display("internal tick done");
		end_sim();
	end
endmodule : tb_stochastic_density_dimmer
